// *** rtl/gpb_port_bank.sv ***
// multi-port gpio bank: control registers, pin drivers and shared reset pin
// Notes on behaviour
// RULE_01: four-bit port with output latch and per-bit direction register.
// RULE_02: four-bit port pull-up only in input mode with its enable bit set.
// RULE_03: two-bit port with latch, direction, pull-ups; bits feed interrupts.
// RULE_04: input-only bit shared with reset; when a port, pin reset is off.
// RULE_05: low on shared pin before setting re-read holds reset until high.
// RULE_06: six-bit port with latch, per-bit direction and input-mode pull-ups.
// RULE_07: three-bit port; pull-up only on its highest bit in input mode.
// RULE_08: clock source decides which low two port-twelve bits remain I/O.
// RULE_09: output-only bit drives low during reset, software may raise it.
// RULE_10: direction registers reset to all ones, every port bit an input.
// RULE_11: direction 0 turns the output buffer on, 1 turns it off.
// RULE_12: writing a data register updates latch; latch drives output pins.
// RULE_13: data read gives pin level for inputs, latch for outputs.
// RULE_14: data registers with output latches clear to zero on reset.
// RULE_15: direction registers take single-bit and whole-byte writes.
// RULE_16: interrupt-capable bit in output mode changing level sets its flag.
// RULE_17: four-bit port pins can serve as converter analog inputs.
// RULE_18: per-bit analog select register for four-bit port, reset zero.
// RULE_19: all pull-up enable registers clear to zero on reset.
// RULE_20: pull-ups drop automatically while a bit is in output mode.
module gpb_port_bank
  import gpb_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire gpb_pkg::gpb_cpu_req_type cpu_req,
  output logic [7:0]                    cpu_rdata_ff,
  output logic                          cpu_rvalid_ff,
  input  wire gpb_pkg::gpb_pins_type    pin_in,
  output gpb_pkg::gpb_pins_type         pin_out_ff,
  output gpb_pkg::gpb_pins_type         pin_oe_ff,
  output gpb_pkg::gpb_pins_type         pin_pu_ff,
  input  wire logic                     shared_reset_input_bit,
  output logic                          output_only_bit_ff,
  input  wire gpb_pkg::gpb_clk_src_type clk_source,
  input  wire logic                     option_ready,
  input  wire logic                     reset_pin_is_port,
  output logic                          sys_reset_req_ff,
  output logic [3:0]                    analog_input_sel_ff,
  output logic [2:0]                    intp_flag_set_ff
);

  logic [7:0]        reg_q [NUM_REGS];
  logic [7:0]        pin_in8 [NUM_PORTS];
  logic [7:0]        port_usable [NUM_PORTS];
  logic [7:0]        nxt_oe [NUM_PORTS];
  logic [7:0]        nxt_out [NUM_PORTS];
  logic [7:0]        nxt_pu [NUM_PORTS];
  logic [7:0]        port_read [NUM_PORTS];
  logic [7:0]        port_two_analog_select;
  logic [7:0]        nxt_rdata;
  gpb_pins_type      nxt_pin_out;
  gpb_pins_type      nxt_pin_oe;
  gpb_pins_type      nxt_pin_pu;
  logic [2:0]        nxt_intp;
  gpb_rst_state_type rst_state_ff;
  gpb_rst_state_type nxt_rst_state;

  // control and data registers
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    gpb_sfr_reg #(
      .ADDR      (REG_ADDR[r]),
      .RESET_VAL (REG_RESET[r]),
      .WMASK     (REG_WMASK[r])
    ) u_reg (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cpu_req (cpu_req),
      .q_ff    (reg_q[r])
    );
  end

  assign port_two_analog_select = reg_q[IDX_PORT_TWO_ANALOG_SELECT]; // RULE_18

  // widen the pin groups to byte lanes matching the register bit positions
  assign pin_in8[0] = {4'h0, pin_in.p2};
  assign pin_in8[1] = {6'h00, pin_in.p3};
  assign pin_in8[2] = {2'h0, pin_in.p4};
  assign pin_in8[3] = {4'h0, pin_in.p12, 1'b0};

  // which pins the port owns right now
  always_comb begin
    port_usable[0] = PORT_MASK[0] & ~port_two_analog_select; // RULE_17
    port_usable[1] = PORT_MASK[1];
    port_usable[2] = PORT_MASK[2];
    case (clk_source) // RULE_08
      CLK_SRC_RING: begin
        port_usable[3] = P12_USABLE_RING;
      end
      CLK_SRC_CRYSTAL: begin
        port_usable[3] = P12_USABLE_CRYSTAL;
      end
      CLK_SRC_EXTCLK: begin
        port_usable[3] = P12_USABLE_EXTCLK;
      end
      default: begin
        port_usable[3] = P12_USABLE_CRYSTAL;
      end
    endcase
  end

  // per-port pin drive, pull-up and read-back
  for (genvar k = 0; k < NUM_PORTS; k++) begin : g_port
    logic [7:0] dir;
    logic [7:0] lat;
    logic [7:0] pu;

    assign dir = reg_q[IDX_DIR_BASE + k];
    assign lat = reg_q[IDX_LATCH_BASE + k];
    assign pu  = reg_q[IDX_PU_BASE + k];

    // buffer on only for direction 0 on an owned pin
    assign nxt_oe[k]  = ~dir & port_usable[k]; // RULE_11
    assign nxt_out[k] = lat & port_usable[k]; // RULE_12
    // pull-up only in input mode with its enable set
    assign nxt_pu[k]  = dir & pu & port_usable[k]; // RULE_20
    // inputs read the pin, outputs read the latch
    assign port_read[k] = ((dir & pin_in8[k]) | (~dir & lat))
                          & port_usable[k]; // RULE_13
  end

  // narrow the byte lanes back to the pin groups
  always_comb begin
    nxt_pin_out.p2  = nxt_out[0][3:0]; // RULE_01
    nxt_pin_out.p3  = nxt_out[1][1:0]; // RULE_03
    nxt_pin_out.p4  = nxt_out[2][5:0]; // RULE_06
    nxt_pin_out.p12 = nxt_out[3][3:1]; // RULE_07
    nxt_pin_oe.p2   = nxt_oe[0][3:0]; // RULE_01
    nxt_pin_oe.p3   = nxt_oe[1][1:0]; // RULE_03
    nxt_pin_oe.p4   = nxt_oe[2][5:0]; // RULE_06
    nxt_pin_oe.p12  = nxt_oe[3][3:1]; // RULE_07
    nxt_pin_pu.p2   = nxt_pu[0][3:0]; // RULE_02
    nxt_pin_pu.p3   = nxt_pu[1][1:0]; // RULE_03
    nxt_pin_pu.p4   = nxt_pu[2][5:0]; // RULE_06
    nxt_pin_pu.p12  = nxt_pu[3][3:1]; // RULE_07
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
      pin_pu_ff  <= '0; // RULE_19
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      pin_pu_ff  <= nxt_pin_pu;
    end
  end

  // output-only bit, held low by its own reset, then following its latch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_only_bit_ff <= 1'b0; // RULE_09
    end else begin
      output_only_bit_ff <= reg_q[IDX_PORT_THIRTEEN_LATCH][0]; // RULE_14
    end
  end

  // converter input selection for the four-bit port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_input_sel_ff <= 4'h0;
    end else begin
      analog_input_sel_ff <= port_two_analog_select[3:0]; // RULE_17
    end
  end

  // a driven interrupt pin changing level looks like an external edge
  always_comb begin
    nxt_intp[0] = nxt_pin_oe.p3[0]
                  && (nxt_pin_out.p3[0] != pin_out_ff.p3[0]); // RULE_16
    nxt_intp[1] = nxt_pin_oe.p3[1]
                  && (nxt_pin_out.p3[1] != pin_out_ff.p3[1]); // RULE_16
    nxt_intp[2] = nxt_pin_oe.p4[3]
                  && (nxt_pin_out.p4[3] != pin_out_ff.p4[3]); // RULE_16
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intp_flag_set_ff <= 3'h0;
    end else begin
      intp_flag_set_ff <= nxt_intp;
    end
  end

  // shared reset pin: reset role until the setting is known
  always_comb begin
    nxt_rst_state = rst_state_ff;
    case (rst_state_ff)
      RST_ARMED: begin
        if (!shared_reset_input_bit) begin
          nxt_rst_state = RST_HOLD; // RULE_05
        end else if (option_ready && reset_pin_is_port) begin
          nxt_rst_state = RST_RUN_PORT; // RULE_04
        end else if (option_ready) begin
          nxt_rst_state = RST_RUN_PIN;
        end
      end
      RST_HOLD: begin
        if (shared_reset_input_bit) begin
          nxt_rst_state = RST_ARMED; // RULE_05
        end
      end
      RST_RUN_PIN: begin
        if (!shared_reset_input_bit) begin
          nxt_rst_state = RST_HOLD;
        end
      end
      RST_RUN_PORT: begin
        nxt_rst_state = RST_RUN_PORT; // RULE_04
      end
      default: begin
        nxt_rst_state = RST_ARMED;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_state_ff <= RST_ARMED;
    end else begin
      rst_state_ff <= nxt_rst_state;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sys_reset_req_ff <= 1'b0;
    end else begin
      sys_reset_req_ff <= (nxt_rst_state == RST_HOLD); // RULE_05
    end
  end

  // read decode
  always_comb begin
    nxt_rdata = 8'h00;
    if (cpu_req.addr == REG_ADDR[IDX_PORT_TWO_DIRECTION]) begin
      nxt_rdata = reg_q[IDX_PORT_TWO_DIRECTION];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_THREE_DIRECTION]) begin
      nxt_rdata = reg_q[IDX_PORT_THREE_DIRECTION];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_FOUR_DIRECTION]) begin
      nxt_rdata = reg_q[IDX_PORT_FOUR_DIRECTION];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWELVE_DIRECTION]) begin
      nxt_rdata = reg_q[IDX_PORT_TWELVE_DIRECTION];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWO_LATCH]) begin
      nxt_rdata = port_read[0]; // RULE_13
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_THREE_LATCH]) begin
      nxt_rdata = port_read[1];
      // shared bit reads its pin whichever role it has
      nxt_rdata[SHARED_RESET_BIT] = shared_reset_input_bit; // RULE_04
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_FOUR_LATCH]) begin
      nxt_rdata = port_read[2];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWELVE_LATCH]) begin
      nxt_rdata = port_read[3];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_THIRTEEN_LATCH]) begin
      nxt_rdata = reg_q[IDX_PORT_THIRTEEN_LATCH];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWO_PULLUP_ENABLE]) begin
      nxt_rdata = reg_q[IDX_PORT_TWO_PULLUP_ENABLE];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_THREE_PULLUP_ENABLE]) begin
      nxt_rdata = reg_q[IDX_PORT_THREE_PULLUP_ENABLE];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_FOUR_PULLUP_ENABLE]) begin
      nxt_rdata = reg_q[IDX_PORT_FOUR_PULLUP_ENABLE];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWELVE_PULLUP_ENABLE]) begin
      nxt_rdata = reg_q[IDX_PORT_TWELVE_PULLUP_ENABLE];
    end else if (cpu_req.addr == REG_ADDR[IDX_PORT_TWO_ANALOG_SELECT]) begin
      nxt_rdata = reg_q[IDX_PORT_TWO_ANALOG_SELECT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata_ff  <= 8'h00;
      cpu_rvalid_ff <= 1'b0;
    end else begin
      cpu_rvalid_ff <= cpu_req.rd;
      if (cpu_req.rd) begin
        cpu_rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule : gpb_port_bank

// *** rtl/gpb_pkg.sv ***
// shared constants and types for the multi-port gpio bank
package gpb_pkg;

  localparam int NUM_REGS  = 14;
  localparam int NUM_PORTS = 4;

  // register indices, directions first, then latches, pull-ups, analog select
  localparam int IDX_PORT_TWO_DIRECTION      = 0;
  localparam int IDX_PORT_THREE_DIRECTION    = 1;
  localparam int IDX_PORT_FOUR_DIRECTION     = 2;
  localparam int IDX_PORT_TWELVE_DIRECTION   = 3;
  localparam int IDX_PORT_TWO_LATCH          = 4;
  localparam int IDX_PORT_THREE_LATCH        = 5;
  localparam int IDX_PORT_FOUR_LATCH         = 6;
  localparam int IDX_PORT_TWELVE_LATCH       = 7;
  localparam int IDX_PORT_THIRTEEN_LATCH     = 8;
  localparam int IDX_PORT_TWO_PULLUP_ENABLE  = 9;
  localparam int IDX_PORT_THREE_PULLUP_ENABLE = 10;
  localparam int IDX_PORT_FOUR_PULLUP_ENABLE = 11;
  localparam int IDX_PORT_TWELVE_PULLUP_ENABLE = 12;
  localparam int IDX_PORT_TWO_ANALOG_SELECT  = 13;

  // base index of the direction, latch and pull-up groups; port k sits at base plus k
  localparam int IDX_DIR_BASE   = 0;
  localparam int IDX_LATCH_BASE = 4;
  localparam int IDX_PU_BASE    = 9;

  localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
    16'hFF22, 16'hFF23, 16'hFF24, 16'hFF2C,
    16'hFF02, 16'hFF03, 16'hFF04, 16'hFF0C, 16'hFF0D,
    16'hFF32, 16'hFF33, 16'hFF34, 16'hFF3C,
    16'hFF84
  };

  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00
  };

  // writable bits; the rest hold their reset value
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
    8'h0F, 8'h03, 8'h3F, 8'h0E,
    8'h0F, 8'h03, 8'h3F, 8'h0E, 8'h01,
    8'h0F, 8'h03, 8'h3F, 8'h08,
    8'h0F
  };

  // pins present in each bidirectional port (two, three, four, twelve)
  localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{
    8'h0F, 8'h03, 8'h3F, 8'h0E
  };

  // input-only shared reset bit position inside the port three read value
  localparam int SHARED_RESET_BIT = 4;

  // port twelve pins left to the port under each clock source
  localparam logic [7:0] P12_USABLE_RING    = 8'h0E;
  localparam logic [7:0] P12_USABLE_CRYSTAL = 8'h08;
  localparam logic [7:0] P12_USABLE_EXTCLK  = 8'h0C;

  typedef enum logic [1:0] {
    CLK_SRC_RING    = 2'b00,
    CLK_SRC_CRYSTAL = 2'b01,
    CLK_SRC_EXTCLK  = 2'b10
  } gpb_clk_src_type;

  typedef enum logic [1:0] {
    RST_ARMED    = 2'b00,
    RST_HOLD     = 2'b01,
    RST_RUN_PIN  = 2'b10,
    RST_RUN_PORT = 2'b11
  } gpb_rst_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } gpb_cpu_req_type;

  typedef struct packed {
    logic [3:0] p2;
    logic [1:0] p3;
    logic [5:0] p4;
    logic [2:0] p12;
  } gpb_pins_type;

endpackage : gpb_pkg

// *** rtl/gpb_sfr_reg.sv ***
// one cpu-writable 8-bit control register with byte and single-bit writes
module gpb_sfr_reg
  import gpb_pkg::*;
#(
  parameter logic [15:0] ADDR      = 16'h0000,
  parameter logic [7:0]  RESET_VAL = 8'h00,
  parameter logic [7:0]  WMASK     = 8'hFF
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire gpb_pkg::gpb_cpu_req_type cpu_req,
  output logic [7:0]                    q_ff
);

  logic [7:0] bit_mask;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;

  always_comb begin
    bit_mask = 8'h01 << cpu_req.bit_sel;
    // a single-bit write touches only the selected bit, with data in bit 0
    wr_mask  = cpu_req.bit_op ? (WMASK & bit_mask) : WMASK; // RULE_15
    wr_data  = cpu_req.bit_op ? {8{cpu_req.wdata[0]}} : cpu_req.wdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_ff <= RESET_VAL; // RULE_10
    end else if (cpu_req.wr && (cpu_req.addr == ADDR)) begin
      q_ff <= (q_ff & ~wr_mask) | (wr_data & wr_mask); // RULE_12
    end
  end

endmodule : gpb_sfr_reg

// *** verification/gpb_pin_model.sv ***
// board-side model of the pins around the gpio bank
module gpb_pin_model (
  input  wire logic                  sys_clk,
  input  wire gpb_pkg::gpb_pins_type pin_out,
  input  wire gpb_pkg::gpb_pins_type pin_oe,
  input  wire gpb_pkg::gpb_pins_type pin_pu,
  input  wire gpb_pkg::gpb_pins_type ext_drv,
  input  wire gpb_pkg::gpb_pins_type ext_en,
  output gpb_pkg::gpb_pins_type      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpb_pkg::*;
  logic [14:0] tog_ff = 15'h5AA5;
  // undriven pins without pull-up wander every cycle
  always_ff @(posedge sys_clk) begin
    tog_ff <= ~tog_ff;
  end
  // device drive wins, then board drive, then pull-up
  assign pin_lvl = gpb_pins_type'((pin_oe & pin_out) |
                   (~pin_oe & ext_en & ext_drv) |
                   (~pin_oe & ~ext_en & (pin_pu | tog_ff)));
endmodule : gpb_pin_model

// *** verification/gpb_port_bank_checker.sv ***
// port-level assertions for the gpio bank
module gpb_port_bank_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire gpb_pkg::gpb_cpu_req_type cpu_req,
  input wire logic                     cpu_rvalid_ff,
  input wire gpb_pkg::gpb_pins_type    pin_out_ff,
  input wire gpb_pkg::gpb_pins_type    pin_oe_ff,
  input wire gpb_pkg::gpb_pins_type    pin_pu_ff,
  input wire logic                     shared_reset_input_bit,
  input wire gpb_pkg::gpb_clk_src_type clk_source,
  input wire logic                     sys_reset_req_ff,
  input wire logic [2:0]               intp_flag_set_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpb_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_dir4_zero;
    cpu_req.wr && !cpu_req.bit_op && cpu_req.addr == 16'hFF24 &&
      cpu_req.wdata == 8'h00;
  endsequence
  sequence s_lat4_wr;
    cpu_req.wr && !cpu_req.bit_op && cpu_req.addr == 16'hFF04;
  endsequence
  a_rd_answer: assert property (cpu_req.rd |=> cpu_rvalid_ff)
    else $error("read not answered");
  a_rv_cause: assert property (cpu_rvalid_ff |-> $past(cpu_req.rd))
    else $error("read valid without read");
  a_pu_in_only: assert property ((pin_pu_ff & pin_oe_ff) == 15'h0)
    else $error("pull-up on driven pin");
  a_pu_p12_high: assert property (pin_pu_ff.p12[1:0] == 2'b00)
    else $error("pull-up on low port twelve pin");
  a_osc_pins: assert property ((clk_source != CLK_SRC_RING) |=>
    !pin_oe_ff.p12[0]) else $error("oscillator input pin driven");
  a_xtal_pins: assert property ((clk_source == CLK_SRC_CRYSTAL) |=>
    pin_oe_ff.p12[1:0] == 2'b00) else $error("crystal pins driven");
  a_rst_rise: assert property ($rose(sys_reset_req_ff) |->
    !$past(shared_reset_input_bit)) else $error("reset without low pin");
  a_rst_drop: assert property (
    sys_reset_req_ff && shared_reset_input_bit |=> !sys_reset_req_ff)
    else $error("reset held after pin high");
  a_intp_cause: assert property (intp_flag_set_ff[0] |->
    pin_oe_ff.p3[0] && pin_out_ff.p3[0] != $past(pin_out_ff.p3[0]))
    else $error("interrupt pulse without level change");
  a_dir4_out: assert property (s_dir4_zero |-> ##2
    pin_oe_ff.p4 == 6'h3F) else $error("port four not driven");
  a_lat4_out: assert property (s_lat4_wr |-> ##2
    {2'b00, pin_out_ff.p4} == ($past(cpu_req.wdata, 2) & 8'h3F))
    else $error("latch not on pins");
endmodule : gpb_port_bank_checker

bind gpb_port_bank gpb_port_bank_checker i_chk (
  .sys_clk, .rst, .cpu_req, .cpu_rvalid_ff, .pin_out_ff, .pin_oe_ff,
  .pin_pu_ff, .shared_reset_input_bit, .clk_source, .sys_reset_req_ff,
  .intp_flag_set_ff
);

// *** verification/tb_multi_port_gpio_bank.sv ***
// self-checking testbench for the multi-port gpio bank
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin \
  fails++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_multi_port_gpio_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import gpb_pkg::*;
  logic            sys_clk, rst, rvalid, srib, oob, option_ready, rpip, sreq;
  logic [7:0]      rdata;
  logic [3:0]      asel;
  logic [2:0]      intp;
  gpb_cpu_req_type req;
  gpb_clk_src_type clk_source;
  gpb_pins_type    pin_in, pin_out, pin_oe, pin_pu, ext_drv, ext_en;
  int              fails, cmp_count;

  gpb_port_bank i_dut (
    .sys_clk, .rst, .cpu_req(req), .cpu_rdata_ff(rdata),
    .cpu_rvalid_ff(rvalid), .pin_in, .pin_out_ff(pin_out),
    .pin_oe_ff(pin_oe), .pin_pu_ff(pin_pu), .shared_reset_input_bit(srib),
    .output_only_bit_ff(oob), .clk_source, .option_ready,
    .reset_pin_is_port(rpip), .sys_reset_req_ff(sreq),
    .analog_input_sel_ff(asel), .intp_flag_set_ff(intp));
  gpb_pin_model i_pins (.sys_clk, .pin_out, .pin_oe, .pin_pu, .ext_drv,
    .ext_en, .pin_lvl(pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic w1;
    @(posedge sys_clk);
    #1;
  endtask : w1
  task automatic wr(logic [15:0] a, logic [7:0] d, logic b = 1'b0,
                    logic [2:0] s = 3'h0);
    @(posedge sys_clk);
    req <= '{a, 1'b1, 1'b0, b, s, d};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge sys_clk);
    req <= '{a, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd

  task automatic t_reset;
    w1;
    `CHK("oe", 15'h0, pin_oe)
    `CHK("out", 15'h0, pin_out)
    `CHK("pu", 15'h0, pin_pu)
    `CHK("oob", 1'b0, oob)
    for (int i = 0; i < 4; i++) rd(REG_ADDR[i], 8'hFF);
    for (int i = 9; i < 14; i++) rd(REG_ADDR[i], 8'h00);
    rd(16'hFF02, 8'h0E);
    rd(16'hFF03, 8'h12);
    rd(16'hFF0C, 8'h0A);
    rd(16'hFF10, 8'h00);
  endtask : t_reset
  task automatic t_pullup;
    wr(16'hFF32, 8'hF5);
    wr(16'hFF33, 8'h03);
    wr(16'hFF34, 8'h3F);
    wr(16'hFF3C, 8'h0F);
    w1;
    `CHK("pu2", 4'h5, pin_pu.p2)
    `CHK("pu3", 2'h3, pin_pu.p3)
    `CHK("pu4", 6'h3F, pin_pu.p4)
    `CHK("port_twelve_pullup_enable", 3'h4, pin_pu.p12)
    rd(16'hFF32, 8'h05);
    wr(16'hFF22, 8'h00, 1'b1, 3'h2);
    w1;
    `CHK("pu2", 4'h1, pin_pu.p2)
    `CHK("oe2", 4'h4, pin_oe.p2)
    rd(16'hFF22, 8'hFB);
    rd(16'hFF02, 8'h0A);
  endtask : t_pullup
  task automatic t_port4;
    wr(16'hFF24, 8'h00);
    rd(16'hFF24, 8'hC0);
    wr(16'hFF04, 8'hEA);
    w1;
    `CHK("oe4", 6'h3F, pin_oe.p4)
    `CHK("out4", 6'h2A, pin_out.p4)
    wr(16'hFF24, 8'h38);
    rd(16'hFF04, 8'h12);
    `CHK("pu4", 6'h38, pin_pu.p4)
  endtask : t_port4
  task automatic t_analog;
    wr(16'hFF22, 8'h00);
    wr(16'hFF02, 8'h0F);
    wr(16'hFF84, 8'h03);
    w1;
    `CHK("asel", 4'h3, asel)
    `CHK("oe2", 4'hC, pin_oe.p2)
    rd(16'hFF02, 8'h0C);
    wr(16'hFF84, 8'h00);
  endtask : t_analog
  task automatic t_clk;
    gpb_clk_src_type s[3] = '{CLK_SRC_RING, CLK_SRC_CRYSTAL, CLK_SRC_EXTCLK};
    logic [7:0] m[3] = '{P12_USABLE_RING, P12_USABLE_CRYSTAL,
                         P12_USABLE_EXTCLK};
    wr(16'hFF2C, 8'h00);
    wr(16'hFF0C, 8'h0E);
    foreach (s[i]) begin
      @(posedge sys_clk);
      clk_source <= s[i];
      w1;
      `CHK("oe12", m[i][3:1], pin_oe.p12)
    end
    rd(16'hFF0C, 8'h0C);
    @(posedge sys_clk);
    clk_source <= CLK_SRC_RING;
  endtask : t_clk
  task automatic t_intp;
    wr(16'hFF23, 8'h00);
    wr(16'hFF24, 8'h00);
    wr(16'hFF03, 8'h01);
    w1;
    `CHK("intp", 3'b001, intp)
    wr(16'hFF04, 8'h00);
    w1;
    `CHK("intp", 3'b100, intp)
    w1;
    `CHK("intp", 3'b000, intp)
  endtask : t_intp
  task automatic t_shared;
    wr(16'hFF0D, 8'h01);
    w1;
    `CHK("oob", 1'b1, oob)
    @(posedge sys_clk);
    srib <= 1'b0;
    w1;
    `CHK("sreq", 1'b1, sreq)
    repeat (3) @(posedge sys_clk);
    srib <= 1'b1;
    w1;
    `CHK("sreq", 1'b0, sreq)
    @(posedge sys_clk);
    option_ready <= 1'b1;
    rpip <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srib <= 1'b0;
    repeat (3) w1;
    `CHK("sreq", 1'b0, sreq)
    rd(16'hFF03, 8'h01);
  endtask : t_shared
  task automatic t_rst;
    @(posedge sys_clk);
    srib <= 1'b1;
    rpip <= 1'b0;
    rst <= 1'b1;
    #1;
    `CHK("oob", 1'b0, oob)
    `CHK("oe", 15'h0, pin_oe)
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(16'hFF0D, 8'h00);
    rd(16'hFF23, 8'hFF);
    // shared pin kept in its reset role: a low level holds the device
    @(posedge sys_clk);
    srib <= 1'b0;
    w1;
    `CHK("sreq", 1'b1, sreq)
    @(posedge sys_clk);
    srib <= 1'b1;
    w1;
    `CHK("sreq", 1'b0, sreq)
  endtask : t_rst

  initial begin
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    req = '0;
    srib = 1'b1;
    option_ready = 1'b0;
    rpip = 1'b0;
    clk_source = CLK_SRC_RING;
    ext_drv = '{4'hE, 2'h2, 6'h15, 3'h5};
    ext_en = '1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_pullup();
    t_port4();
    t_analog();
    t_clk();
    t_intp();
    t_shared();
    t_rst();
    summarize();
  end

  initial begin
    #20us;
    fails++;
    summarize();
  end
endmodule : tb_multi_port_gpio_bank
